// file: verilog/dcpll_pkg.sv
/*
 * Constants, register map and types of the converter clock and PLL control block.
 * Assumes a 32-bit APB master, with register indices multiplied by four to give byte addresses.
 */
package dcpll_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [11:0] IDX_OUTDIV = 12'h094;
	localparam logic [11:0] IDX_BYPASS = 12'h095;
	localparam logic [11:0] IDX_CALCTL = 12'h792;
	localparam logic [11:0] IDX_PREDIV = 12'h793;
	localparam logic [11:0] IDX_CPCUR = 12'h794;
	localparam logic [11:0] IDX_LOCK = 12'h7B5;
	localparam logic [11:0] IDX_FBDIV = 12'h7B0;
	localparam logic [11:0] IDX_DCC = 12'h7B1;
	localparam logic [11:0] IDX_IRQSTAT = 12'h7B2;
	localparam logic [11:0] IDX_IRQMASK = 12'h7B3;
	localparam int ADDR_LSB = 2;

	// Reset values.
	localparam logic [7:0] RST_BYPASS = 8'h01;
	localparam logic [1:0] RST_OUTDIV = 2'h0;
	localparam logic [1:0] RST_PREDIV = 2'h0;
	localparam logic [5:0] RST_CPCUR = 6'h08;
	localparam logic [5:0] RST_FBDIV = 6'h0A;
	localparam logic RST_DCC = 1'b1;
	localparam logic [3:0] RST_MASK = 4'h0;

	// Field positions.
	localparam int BIT_BYPASS = 0;
	localparam int BIT_CALTRIG = 1;
	localparam int BIT_LOCK = 0;
	localparam int BIT_DCC = 0;

	// Feedback divider legal range and the fixed VCO multiplier.
	localparam logic [5:0] FBDIV_MIN = 6'h02;
	localparam logic [5:0] FBDIV_MAX = 6'h32;
	localparam int VCO_MULT = 8;

	// Interrupt status bit positions.
	localparam int EV_CALDONE = 0;
	localparam int EV_LOCKGAIN = 1;
	localparam int EV_LOCKLOST = 2;
	localparam int EV_FBRANGE = 3;
	localparam int NUM_EV = 4;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CAL = 2'b01,
		ST_WAITLOCK = 2'b10,
		ST_LOCKED = 2'b11
	} dcpll_state_t;

	// Settings handed to the analog clock generation.
	typedef struct packed
	{
		logic usePll;
		logic [1:0] predivSel;
		logic [1:0] outDivSel;
		logic [5:0] fbDiv;
		logic [5:0] pllChargePumpCurrent;
		logic dccEnable;
		logic vcoCalRun;
	} dcpll_cfg_t;
endpackage : dcpll_pkg

// file: verilog/dcpll_ctrl.sv
/*
 * Digital control of converter sample clock generation: clock source choice, dividers,
 * VCO calibration sequencing, lock indication and interrupt, with an APB register slave.
 * Assumes pins are synchronous to clk and that the analog PLL reports its lock detector
 * level on lockDetIn.
 */
module dcpll_ctrl
	import dcpll_pkg::*;
#(
	parameter int CAL_CYCLES = 1024,
	parameter int ADDR_W = 16
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lockDetIn,
	output dcpll_cfg_t pllCfg,
	output logic [8:0] ratioNum,
	output logic [4:0] ratioDen,
	output logic pllLocked,
	output logic irq
);
	localparam int CNT_W = $clog2(CAL_CYCLES + 1);
	localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);

	logic [7:0] bypass_r, bypass_nxt;
	logic [1:0] outDiv_r, outDiv_nxt;
	logic [1:0] prediv_r, prediv_nxt;
	logic [5:0] cpCur_r, cpCur_nxt;
	logic [5:0] fbDiv_r, fbDiv_nxt;
	logic calTrig_r, calTrig_nxt;
	logic dcc_r, dcc_nxt;
	logic [NUM_EV-1:0] irqStat_r, irqStat_nxt;
	logic [NUM_EV-1:0] irqMask_r, irqMask_nxt;
	logic ack_r, ack_nxt;
	logic err_r, err_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	dcpll_state_t state_r, state_nxt;
	logic [CNT_W-1:0] calCnt_r, calCnt_nxt;
	logic [8:0] ratioNum_r, ratioNum_nxt;
	logic [4:0] ratioDen_r, ratioDen_nxt;
	logic irq_r, irq_nxt;

	localparam int IDX_W = 12;
	logic [IDX_W-1:0] idx;
	logic wrEn;
	logic calStart;
	logic divWrite;
	logic [NUM_EV-1:0] events;
	logic accessStart;
	logic addrBad;
	logic fbOutOfRange;
	logic lockedNow;
	logic [NUM_EV-1:0] statClr;

	assign idx = paddr[ADDR_LSB +: IDX_W];
	assign wrEn = psel & penable & pwrite & ack_r & ~err_r;
	assign accessStart = psel & penable & ~ack_r;
	assign addrBad = (paddr[ADDR_LSB-1:0] != '0) || (paddr[ADDR_W-1:ADDR_LSB+IDX_W] != '0);
	assign fbOutOfRange = (pwdata[5:0] < FBDIV_MIN) || (pwdata[5:0] > FBDIV_MAX);
	assign lockedNow = (state_r == ST_LOCKED);

	// Register file. The answer is registered, so every access carries one wait state and
	// read data comes from a flop; a refused access still answers, with its error flag.
	always_comb
	begin
		bypass_nxt = bypass_r;
		outDiv_nxt = outDiv_r;
		prediv_nxt = prediv_r;
		cpCur_nxt = cpCur_r;
		fbDiv_nxt = fbDiv_r;
		calTrig_nxt = calTrig_r;
		dcc_nxt = dcc_r;
		irqMask_nxt = irqMask_r;
		ack_nxt = accessStart;
		err_nxt = err_r;
		rdata_nxt = rdata_r;
		calStart = 1'b0;
		divWrite = 1'b0;
		if (accessStart)
		begin
			err_nxt = 1'b0;
			rdata_nxt = '0;
			unique case (idx)
				IDX_BYPASS: rdata_nxt[7:0] = bypass_r;
				IDX_OUTDIV: rdata_nxt[1:0] = outDiv_r;
				IDX_PREDIV: rdata_nxt[1:0] = prediv_r;
				IDX_CPCUR: rdata_nxt[5:0] = cpCur_r;
				IDX_FBDIV: rdata_nxt[5:0] = fbDiv_r;
				IDX_CALCTL: rdata_nxt[BIT_CALTRIG] = calTrig_r;
				IDX_DCC: rdata_nxt[BIT_DCC] = dcc_r;
				IDX_LOCK: rdata_nxt[BIT_LOCK] = lockedNow;
				IDX_IRQSTAT: rdata_nxt[NUM_EV-1:0] = irqStat_r;
				IDX_IRQMASK: rdata_nxt[NUM_EV-1:0] = irqMask_r;
				default: err_nxt = 1'b1;
			endcase
			if (addrBad)
			begin
				err_nxt = 1'b1;
			end
		end
		// Writes land at the end of the access phase. The lock register ignores writes, and
		// the status register is cleared by the per-flag logic further down.
		if (wrEn)
		begin
			unique case (idx)
				IDX_BYPASS: bypass_nxt = pwdata[7:0];
				IDX_OUTDIV:
				begin
					outDiv_nxt = pwdata[1:0];
					divWrite = 1'b1;
				end
				IDX_PREDIV:
				begin
					prediv_nxt = pwdata[1:0];
					divWrite = 1'b1;
				end
				IDX_CPCUR: cpCur_nxt = pwdata[5:0];
				IDX_FBDIV:
				begin
					fbDiv_nxt = pwdata[5:0];
					divWrite = 1'b1;
				end
				// Only a falling trigger starts a run, so rewriting zero is harmless.
				IDX_CALCTL:
				begin
					calTrig_nxt = pwdata[BIT_CALTRIG];
					calStart = calTrig_r & ~pwdata[BIT_CALTRIG];
				end
				IDX_DCC: dcc_nxt = pwdata[BIT_DCC];
				IDX_IRQMASK: irqMask_nxt = pwdata[NUM_EV-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			bypass_r <= RST_BYPASS;
			outDiv_r <= RST_OUTDIV;
			prediv_r <= RST_PREDIV;
			cpCur_r <= RST_CPCUR;
			fbDiv_r <= RST_FBDIV;
			calTrig_r <= 1'b0;
			dcc_r <= RST_DCC;
			irqMask_r <= RST_MASK;
			ack_r <= 1'b0;
			err_r <= 1'b0;
			rdata_r <= '0;
		end
		else
		begin
			bypass_r <= bypass_nxt;
			outDiv_r <= outDiv_nxt;
			prediv_r <= prediv_nxt;
			cpCur_r <= cpCur_nxt;
			fbDiv_r <= fbDiv_nxt;
			calTrig_r <= calTrig_nxt;
			dcc_r <= dcc_nxt;
			irqMask_r <= irqMask_nxt;
			ack_r <= ack_nxt;
			err_r <= err_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Calibration and lock sequencing. A new divider setting leaves the VCO on a band picked
	// for the old one, so any divider write or a return to bypass drops lock and the host
	// has to calibrate again.
	always_comb
	begin
		state_nxt = state_r;
		calCnt_nxt = calCnt_r;
		events = '0;
		unique case (state_r)
			ST_IDLE:
			begin
				calCnt_nxt = '0;
			end
			ST_CAL:
			begin
				// The run length is fixed; the analog side calibrates while vcoCalRun stands.
				calCnt_nxt = calCnt_r + 1'b1;
				if (calCnt_r == CAL_LAST)
				begin
					state_nxt = ST_WAITLOCK;
					events[EV_CALDONE] = 1'b1;
				end
			end
			ST_WAITLOCK:
			begin
				// The detector level is taken as synchronous; a one-cycle glitch counts as lock.
				if (lockDetIn)
				begin
					state_nxt = ST_LOCKED;
					events[EV_LOCKGAIN] = 1'b1;
				end
			end
			ST_LOCKED:
			begin
				// A lost lock is reported once; lock is then sought again without a new run.
				if (!lockDetIn)
				begin
					state_nxt = ST_WAITLOCK;
					events[EV_LOCKLOST] = 1'b1;
				end
			end
		endcase
		if (bypass_r[BIT_BYPASS] || divWrite)
		begin
			state_nxt = ST_IDLE;
			events[EV_LOCKLOST] = (state_r == ST_LOCKED);
		end
		else if (calStart)
		begin
			state_nxt = ST_CAL;
			calCnt_nxt = '0;
		end
		if (wrEn && idx == IDX_FBDIV && fbOutOfRange)
		begin
			events[EV_FBRANGE] = 1'b1;
		end
		// Converter to reference clock ratio, one cycle behind the divider registers.
		ratioNum_nxt = 9'(VCO_MULT * fbDiv_r);
		ratioDen_nxt = 5'((prediv_r + 3'd1) * (outDiv_r + 3'd1));
	end

	// Sticky status flags, one per event. An event in the cycle of a write-one clear wins,
	// so an event is never lost to the clear of a flag that software has already seen.
	for (genvar ev = 0; ev < NUM_EV; ev++)
	begin : gStatus
		assign statClr[ev] = wrEn && (idx == IDX_IRQSTAT) && pwdata[ev];
		assign irqStat_nxt[ev] = events[ev] | (irqStat_r[ev] & ~statClr[ev]);
	end
	assign irq_nxt = |(irqStat_nxt & irqMask_nxt);

	// Sequencer, status, interrupt and ratio registers.
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state_r <= ST_IDLE;
			calCnt_r <= '0;
			irqStat_r <= '0;
			irq_r <= 1'b0;
			ratioNum_r <= '0;
			ratioDen_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			calCnt_r <= calCnt_nxt;
			irqStat_r <= irqStat_nxt;
			irq_r <= irq_nxt;
			ratioNum_r <= ratioNum_nxt;
			ratioDen_r <= ratioDen_nxt;
		end
	end

	// Settings to the analog clock generation come straight from flops, except usePll, the inverted bypass bit, and vcoCalRun, decoded from state_r.
	always_comb
	begin
		pllCfg.usePll = ~bypass_r[BIT_BYPASS];
		pllCfg.predivSel = prediv_r;
		pllCfg.outDivSel = outDiv_r;
		pllCfg.fbDiv = fbDiv_r;
		pllCfg.pllChargePumpCurrent = cpCur_r;
		pllCfg.dccEnable = dcc_r;
		pllCfg.vcoCalRun = (state_r == ST_CAL);
	end

	assign pready = ack_r;
	// The error flag outlives its access, so it is shown only together with pready.
	assign pslverr = ack_r & err_r;
	assign prdata = rdata_r;
	assign pllLocked = lockedNow;
	assign ratioNum = ratioNum_r;
	assign ratioDen = ratioDen_r;
	assign irq = irq_r;
endmodule : dcpll_ctrl

// file: verif/dcpll_ctrl_properties.sv
/*
 * Port checker of the clock control block.
 * Assumes a bind from the bench and CAL_CYCLES set to 4.
 */
module dcpll_ctrl_properties
	import dcpll_pkg::*;
#(
	parameter int CAL_CYCLES = 4,
	parameter int ADDR_W = 16
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic lockDetIn,
	input dcpll_cfg_t pllCfg,
	input wire logic [8:0] ratioNum,
	input wire logic [4:0] ratioDen,
	input wire logic pllLocked
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic wr;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	rdy_wait_a: assert property ($rose(penable) && psel |=> pready)
		else $error("pready not in second access cycle");
	src_write_a: assert property ($changed(pllCfg.usePll) |-> $past(wr && paddr[13:2] == IDX_BYPASS))
		else $error("clock source changed without bypass write");
	out_write_a: assert property ($changed(pllCfg.outDivSel) |-> $past(wr && paddr[13:2] == IDX_OUTDIV))
		else $error("output divider changed without write");
	num_ratio_a: assert property ($past(rst_b) |-> ratioNum == 9'(VCO_MULT * $past(pllCfg.fbDiv)))
		else $error("ratio numerator wrong");
	den_ratio_a: assert property ($past(rst_b) |->
		ratioDen == 5'(($past(pllCfg.predivSel) + 3'h1) * ($past(pllCfg.outDivSel) + 3'h1)))
		else $error("ratio denominator wrong");
	cal_len_a: assert property ($rose(pllCfg.vcoCalRun) |-> pllCfg.vcoCalRun[*4] ##1 !pllCfg.vcoCalRun)
		else $error("calibration length wrong");
	lock_src_a: assert property ($rose(pllLocked) |-> $past(lockDetIn) && pllCfg.usePll)
		else $error("lock without detector or in bypass");
	dcc_reset_a: assert property (!$past(rst_b) |-> pllCfg.dccEnable)
		else $error("duty cycle correction off after reset");
endmodule : dcpll_ctrl_properties

// file: verif/dcpll_lock_model.sv
/*
 * Analog lock detector stand-in: reports lock some cycles after a calibration ends.
 * Assumes calRun and usePll come from the block's configuration output.
 */
module dcpll_lock_model
#(
	parameter int DLY = 3
)
(
	input wire logic clk,
	input wire logic calRun,
	input wire logic usePll,
	output logic lockDetIn = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic armed = 1'b0;
	// Lock comes only from a finished calibration with the PLL in use.
	always @(posedge clk)
	begin
		armed <= usePll && (armed || calRun);
		cnt <= (calRun || !armed) ? 0 : (cnt < DLY ? cnt + 1 : cnt);
		lockDetIn <= armed && !calRun && cnt == DLY;
	end
endmodule : dcpll_lock_model

// file: verif/dcpll_ctrl_tb.sv
/*
 * Self-checking bench of the clock control block: registers, dividers, calibration, interrupt.
 * Assumes the checker and the lock detector model are compiled before it.
 */
module dcpll_ctrl_tb
	import dcpll_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000, prdata, q;
	logic pready, pslverr, lockDetIn, pllLocked, irq, e;
	dcpll_cfg_t pllCfg;
	logic [8:0] ratioNum;
	logic [4:0] ratioDen;
	int errTotal = 0, checksDone = 0, cyc = 0;
	dcpll_ctrl #(.CAL_CYCLES(4), .ADDR_W(16)) uut (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lockDetIn(lockDetIn), .pllCfg(pllCfg),
		.ratioNum(ratioNum), .ratioDen(ratioDen), .pllLocked(pllLocked), .irq(irq));
	dcpll_lock_model #(.DLY(3)) lockDet (.clk(clk), .calRun(pllCfg.vcoCalRun),
		.usePll(pllCfg.usePll), .lockDetIn(lockDetIn));
	initial
		forever #2 clk = ~clk;
	task conclude;
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errTotal++;
			conclude;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			errTotal++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h00000000);
		chk(q, exp);
	endtask : rd
	task t_reset;
		rd(IDX_BYPASS, 32'h00000001);
		rd(IDX_FBDIV, 32'h0000000A);
		rd(IDX_CPCUR, 32'h00000008);
		rd(IDX_DCC, 32'h00000001);
		chk(pllCfg.dccEnable, 32'h00000001);
		chk(ratioNum, 32'h00000050);
		rd(12'h001, 32'h00000000);
		chk(e, 32'h00000001);
		$display("test reset done");
	endtask : t_reset
	task t_div;
		int i;
		apb(1'b1, IDX_FBDIV, 32'h00000033);
		rd(IDX_IRQSTAT, 32'h00000008);
		apb(1'b1, IDX_IRQSTAT, 32'h00000008);
		rd(IDX_IRQSTAT, 32'h00000000);
		apb(1'b1, IDX_FBDIV, 32'h00000032);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, IDX_PREDIV, i);
			apb(1'b1, IDX_OUTDIV, i % 3);
			repeat (2) @(negedge clk);
			chk(pllCfg.predivSel, i);
			chk(pllCfg.outDivSel, i % 3);
			chk(ratioDen, (i + 1) * (i % 3 + 1));
			chk(ratioNum, 32'h00000190);
		end
		$display("test dividers done");
	endtask : t_div
	task t_lock;
		apb(1'b1, IDX_IRQMASK, 32'h0000000F);
		// With a 100 MHz reference these give a 9.6 GHz VCO and a 100 MHz phase detector.
		apb(1'b1, IDX_PREDIV, 32'h00000000);
		apb(1'b1, IDX_FBDIV, 32'h0000000C);
		apb(1'b1, IDX_OUTDIV, 32'h00000000);
		apb(1'b1, IDX_CPCUR, 32'h0000000C);
		apb(1'b1, IDX_BYPASS, 32'h00000000);
		repeat (2) @(negedge clk);
		chk(pllCfg.usePll, 32'h00000001);
		chk(pllCfg.pllChargePumpCurrent, 32'h0000000C);
		chk(ratioNum, 32'h00000060);
		chk(ratioDen, 32'h00000001);
		apb(1'b1, IDX_CALCTL, 32'h00000002);
		repeat (2) @(negedge clk);
		chk(pllCfg.vcoCalRun, 32'h00000000);
		apb(1'b1, IDX_CALCTL, 32'h00000000);
		while (pllLocked !== 1'b1)
			@(negedge clk);
		rd(IDX_LOCK, 32'h00000001);
		chk(irq, 32'h00000001);
		rd(IDX_IRQSTAT, 32'h00000003);
		apb(1'b1, IDX_IRQMASK, 32'h00000000);
		repeat (2) @(negedge clk);
		chk(irq, 32'h00000000);
		apb(1'b1, IDX_IRQSTAT, 32'h00000003);
		rd(IDX_IRQSTAT, 32'h00000000);
		apb(1'b1, IDX_IRQMASK, 32'h0000000F);
		apb(1'b1, IDX_BYPASS, 32'h00000001);
		repeat (2) @(negedge clk);
		chk(pllLocked, 32'h00000000);
		chk(irq, 32'h00000001);
		rd(IDX_IRQSTAT, 32'h00000004);
		$display("test lock done");
	endtask : t_lock
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_reset;
		t_div;
		t_lock;
		conclude;
	end
endmodule : dcpll_ctrl_tb

bind dcpll_ctrl dcpll_ctrl_properties #(.CAL_CYCLES(CAL_CYCLES), .ADDR_W(ADDR_W)) props (
	.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .lockDetIn(lockDetIn), .pllCfg(pllCfg),
	.ratioNum(ratioNum), .ratioDen(ratioDen), .pllLocked(pllLocked));
